// [shared/ncc_defines.svh]
// Function
// - Setting receive enable lets the receive buffering engine move data to memory.
// - Enable set mid-packet keeps both bits set and starts buffering only at idle.
// - Setting receive disable stops buffering to memory and the receive FIFO.
// - Disable set mid-packet acts after the packet is processed, both bits set meanwhile.
// - When the receiver becomes disabled the hardware clears receive enable.
// - Tally counters keep counting whatever the receive disable bit holds.
// - With both receive bits set, writing zero to receive disable clears it.
// - Setting transmit packets loads the descriptor area registers, then transmits.
// - Transmit packets clears on end of list, on a halt taking effect, or on abort.
// - An abort is any of excess collision, excess deferral, underrun or count mismatch.
// - Halt stops transmission after the current packet, then transmit packets clears.
// - Halt is sampled only after the packet status word is written back.
`ifndef NCC_DEFINES_SVH
`define NCC_DEFINES_SVH

// =====================================
// Register offsets
`define NCC_OFF_CMD 12'h000
`define NCC_OFF_TX_STAT 12'h004
`define NCC_OFF_CUR_DESC 12'h008
`define NCC_OFF_RES_PTR 12'h00c
`define NCC_OFF_TALLY 12'h010

// =====================================
// Command register fields
`define NCC_CMD_HALT_TX 0
`define NCC_CMD_TX_PKT 1
`define NCC_CMD_RX_DIS 2
`define NCC_CMD_RX_EN 3
`define NCC_CMD_RST 7
`define NCC_CMD_RES_RD 8
`define NCC_CMD_RESET 16'h0080

// =====================================
// Transmit control status fields
`define NCC_TXS_CNT_MISMATCH 0
`define NCC_TXS_UNDERRUN 1
`define NCC_TXS_DEFER_LIMIT 2
`define NCC_TXS_COLL_LIMIT 3

`endif

// [shared/ncc_pkg.sv]
package ncc_pkg;
    typedef struct packed {
        logic [31:0] desc_addr;
        logic end_of_list_flag;
        logic excess_collision_flag;
        logic excess_deferral_flag;
        logic fifo_underrun_flag;
        logic byte_count_mismatch_flag;
    } ncc_tx_wb_t;

    typedef enum logic [1:0] {
        NCC_TX_IDLE = 2'b00,
        NCC_TX_LOAD = 2'b01,
        NCC_TX_SEND = 2'b10
    } ncc_tx_state_t;
endpackage

// [verilog/ncc_top.sv]
`timescale 1ns/1ps
`include "ncc_defines.svh"

module ncc_top
    import ncc_pkg::*;
#(
    parameter int TALLY_W = 16
)(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_rx_busy,
    input wire logic i_rx_tally,
    input wire logic i_tx_loaded,
    input wire logic i_tx_wb_valid,
    input wire ncc_tx_wb_t i_tx_wb,
    input wire logic i_res_rd_done,
    output logic o_rx_buffer_en,
    output logic o_tx_load_req,
    output logic o_tx_run,
    output logic o_res_rd_req,
    output logic [31:0] o_res_rd_ptr,
    output logic o_sw_reset,
    output logic o_crc_disable
);

    // =====================================
    // Reset release
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // =====================================
    // APB decode
    logic ready_q;
    logic err_q;
    logic [31:0] rdata_q;
    logic rx_en_q, rx_dis_q, tx_pkt_q, tx_halt_q, rst_q, res_rd_q, buf_en_q;
    logic [3:0] tx_stat_q;
    logic [31:0] cur_desc_q, res_ptr_q;
    logic [TALLY_W-1:0] tally_q;
    ncc_tx_state_t tx_st_q;
    localparam logic [15:0] CMD_RESET = `NCC_CMD_RESET;

    wire setup = i_psel & ~i_penable;
    wire wr_acc = i_psel & i_penable & ready_q & i_pwrite;
    wire hit_cmd = i_paddr == `NCC_OFF_CMD;
    wire hit_tx_stat = i_paddr == `NCC_OFF_TX_STAT;
    wire hit_cur_desc = i_paddr == `NCC_OFF_CUR_DESC;
    wire hit_res_ptr = i_paddr == `NCC_OFF_RES_PTR;
    wire hit_tally = i_paddr == `NCC_OFF_TALLY;
    wire mapped = hit_cmd | hit_tx_stat | hit_cur_desc | hit_res_ptr | hit_tally;
    wire wr_cmd = wr_acc & hit_cmd & ~err_q;
    wire wr_res_ptr = wr_acc & hit_res_ptr & ~err_q;
    wire [15:0] cmd_rd = {7'h00, res_rd_q, rst_q, 3'h0, rx_en_q, rx_dis_q, tx_pkt_q, tx_halt_q};
    wire [31:0] rd_mux = hit_cmd ? {16'h0000, cmd_rd} :
                         hit_tx_stat ? {28'h0000000, tx_stat_q} :
                         hit_cur_desc ? cur_desc_q :
                         hit_res_ptr ? res_ptr_q :
                         hit_tally ? {{(32-TALLY_W){1'b0}}, tally_q} : 32'h00000000;

    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ready_q <= setup;
            err_q <= setup & ~mapped;
            rdata_q <= (setup & ~i_pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // =====================================
    // Command write decode
    wire w_rx_en = wr_cmd & i_pwdata[`NCC_CMD_RX_EN];
    wire w_rx_dis1 = wr_cmd & i_pwdata[`NCC_CMD_RX_DIS];
    wire w_rx_dis0 = wr_cmd & ~i_pwdata[`NCC_CMD_RX_DIS];
    wire w_tx_pkt = wr_cmd & i_pwdata[`NCC_CMD_TX_PKT];
    wire w_tx_halt = wr_cmd & i_pwdata[`NCC_CMD_HALT_TX];
    wire w_res_rd = wr_cmd & i_pwdata[`NCC_CMD_RES_RD];

    // =====================================
    // Receive enable and disable
    wire rx_go = rx_en_q & ~buf_en_q & ~i_rx_busy;
    wire rx_stop = rx_dis_q & buf_en_q & ~i_rx_busy;
    logic rx_en_d, rx_dis_d, buf_en_d;

    always_comb
    begin
        rx_en_d = rx_en_q;
        rx_dis_d = rx_dis_q;
        buf_en_d = buf_en_q;
        if (rx_go)
        begin
            buf_en_d = 1'b1;
            rx_dis_d = 1'b0;
        end
        if (rx_stop)
        begin
            buf_en_d = 1'b0;
            rx_en_d = 1'b0;
        end
        if (w_rx_dis1)
            rx_dis_d = 1'b1;
        else if (w_rx_dis0 && rx_en_q && rx_dis_q)
            rx_dis_d = 1'b0;
        if (w_rx_en)
        begin
            rx_en_d = 1'b1;
            if (!i_rx_busy)
                rx_dis_d = 1'b0;
            else
                rx_dis_d = 1'b1;
        end
        if (rst_q)
        begin
            buf_en_d = 1'b0;
            rx_en_d = 1'b0;
        end
    end

    // =====================================
    // Transmit sequencing
    wire tx_abort = i_tx_wb.excess_collision_flag | i_tx_wb.excess_deferral_flag |
                    i_tx_wb.fifo_underrun_flag | i_tx_wb.byte_count_mismatch_flag;
    wire tx_wb = i_tx_wb_valid & (tx_st_q == NCC_TX_SEND);
    // Halt sampled only at status write-back
    wire tx_end = tx_wb & (i_tx_wb.end_of_list_flag | tx_halt_q | tx_abort);
    ncc_tx_state_t tx_st_d;
    logic tx_pkt_d, tx_halt_d;

    always_comb
    begin
        tx_st_d = tx_st_q;
        tx_pkt_d = tx_pkt_q;
        tx_halt_d = tx_halt_q;
        case (tx_st_q)
            NCC_TX_IDLE:
                if (tx_pkt_q)
                    tx_st_d = NCC_TX_LOAD;
            NCC_TX_LOAD:
                if (i_tx_loaded)
                    tx_st_d = NCC_TX_SEND;
            NCC_TX_SEND:
                if (tx_end)
                begin
                    tx_st_d = NCC_TX_IDLE;
                    tx_pkt_d = 1'b0;
                    if (tx_halt_q)
                        tx_halt_d = 1'b0;
                end
            default:
                tx_st_d = NCC_TX_IDLE;
        endcase
        if (w_tx_halt)
            tx_halt_d = 1'b1;
        if (w_tx_pkt)
            tx_pkt_d = 1'b1;
        if (rst_q)
        begin
            tx_st_d = NCC_TX_IDLE;
            tx_pkt_d = 1'b0;
            tx_halt_d = 1'b0;
        end
    end

    // =====================================
    // Command and status registers
    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rx_en_q <= 1'b0;
            rx_dis_q <= 1'b0;
            buf_en_q <= 1'b0;
            tx_pkt_q <= 1'b0;
            tx_halt_q <= 1'b0;
            tx_st_q <= NCC_TX_IDLE;
            rst_q <= CMD_RESET[`NCC_CMD_RST];
            res_rd_q <= 1'b0;
        end
        else
        begin
            rx_en_q <= rx_en_d;
            rx_dis_q <= rx_dis_d;
            buf_en_q <= buf_en_d;
            tx_pkt_q <= tx_pkt_d;
            tx_halt_q <= tx_halt_d;
            tx_st_q <= tx_st_d;
            if (wr_cmd)
                rst_q <= i_pwdata[`NCC_CMD_RST];
            if (w_res_rd)
                res_rd_q <= 1'b1;
            else if (i_res_rd_done || rst_q)
                res_rd_q <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            tx_stat_q <= 4'h0;
            cur_desc_q <= 32'h00000000;
            res_ptr_q <= 32'h00000000;
            tally_q <= '0;
        end
        else
        begin
            if (tx_wb)
            begin
                cur_desc_q <= i_tx_wb.desc_addr;
                tx_stat_q <= {i_tx_wb.excess_collision_flag, i_tx_wb.excess_deferral_flag,
                              i_tx_wb.fifo_underrun_flag, i_tx_wb.byte_count_mismatch_flag};
            end
            if (wr_res_ptr)
                res_ptr_q <= i_pwdata;
            if (i_rx_tally && !rst_q)
                tally_q <= tally_q + 1'b1;
        end
    end

    // =====================================
    // Registered outputs
    always_ff @(posedge i_ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            o_tx_load_req <= 1'b0;
            o_tx_run <= 1'b0;
            o_res_rd_req <= 1'b0;
            o_res_rd_ptr <= 32'h00000000;
            o_sw_reset <= 1'b1;
            o_crc_disable <= 1'b1;
        end
        else
        begin
            o_tx_load_req <= tx_st_d == NCC_TX_LOAD;
            o_tx_run <= tx_st_d == NCC_TX_SEND;
            o_res_rd_req <= res_rd_q & ~i_res_rd_done & ~rst_q;
            o_res_rd_ptr <= res_ptr_q;
            o_sw_reset <= rst_q;
            o_crc_disable <= rst_q;
        end
    end

    assign o_rx_buffer_en = buf_en_q;
    assign o_prdata = rdata_q;
    assign o_pready = ready_q;
    assign o_pslverr = err_q;

    // =====================================
    // Assertions
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!rst_n_q);

    rx_start_idle_a: assert property ($rose(buf_en_q) |-> !$past(i_rx_busy))
        else $error("buffering started mid-packet");
    rx_stop_idle_a: assert property ($fell(buf_en_q) && !$past(rst_q)
        && !$past(w_rx_en) |-> !$past(i_rx_busy) && !rx_en_q)
        else $error("receiver stopped mid-packet or enable kept");
    rx_en_clr_a: assert property (w_rx_en && !i_rx_busy && !rst_q
        |=> rx_en_q && !rx_dis_q)
        else $error("enable write did not clear disable");
    rx_both_set_a: assert property (w_rx_en && i_rx_busy && !buf_en_q && !rst_q
        |=> rx_en_q && rx_dis_q)
        else $error("enable mid-packet did not hold both bits");
    rx_dis_zero_a: assert property (w_rx_dis0 && !w_rx_en && rx_en_q && rx_dis_q
        && !rx_go |=> !rx_dis_q)
        else $error("zero write left disable set");
    tx_end_clr_a: assert property (tx_end && !w_tx_pkt
        |=> !tx_pkt_q && tx_st_q == NCC_TX_IDLE)
        else $error("transmit bit not cleared at end");
    tx_load_a: assert property (tx_pkt_q && tx_st_q == NCC_TX_IDLE && !rst_q
        |=> o_tx_load_req ##0 tx_st_q == NCC_TX_LOAD)
        else $error("transmit start without load");
    tx_halt_wait_a: assert property (tx_halt_q && tx_st_q == NCC_TX_SEND
        && !i_tx_wb_valid && !rst_q |=> tx_pkt_q)
        else $error("halt acted before write-back");
    desc_hold_a: assert property (tx_wb |=> cur_desc_q == $past(i_tx_wb.desc_addr))
        else $error("descriptor address not captured");
    tally_run_a: assert property (i_rx_tally && !rst_q && rx_dis_q
        |=> tally_q == $past(tally_q) + 1'b1)
        else $error("tally stopped while disabled");
    sw_rst_a: assert property (rst_q |=> o_sw_reset && o_crc_disable && !buf_en_q)
        else $error("software reset not applied");

    rx_enable_c: cover property (w_rx_en ##[1:20] $rose(buf_en_q));
    rx_late_c: cover property (w_rx_dis1 && i_rx_busy ##[1:50] $fell(buf_en_q));
    tx_halt_c: cover property (tx_halt_q && tx_end);
    tx_abort_c: cover property (tx_wb && tx_abort);

endmodule

// [dv/tb_network_command_control.sv]
`timescale 1ns/1ps
`include "ncc_defines.svh"

module tb_network_command_control;
    import ncc_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0;
    logic i_rx_busy = 1'b0;
    logic i_rx_tally = 1'b0;
    logic i_tx_loaded = 1'b0;
    logic i_tx_wb_valid = 1'b0;
    ncc_tx_wb_t i_tx_wb = '0;
    logic i_res_rd_done = 1'b0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_rx_buffer_en, o_tx_load_req, o_tx_run;
    logic o_res_rd_req, o_sw_reset, o_crc_disable;
    logic [31:0] o_res_rd_ptr;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 32'hd6a2a8e7;
    int ntally = 0;
    logic [31:0] rd, ptr;
    logic err;
    ncc_tx_wb_t wb;

    ncc_top DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_rx_busy(i_rx_busy), .i_rx_tally(i_rx_tally),
        .i_tx_loaded(i_tx_loaded), .i_tx_wb_valid(i_tx_wb_valid), .i_tx_wb(i_tx_wb),
        .i_res_rd_done(i_res_rd_done), .o_rx_buffer_en(o_rx_buffer_en),
        .o_tx_load_req(o_tx_load_req), .o_tx_run(o_tx_run), .o_res_rd_req(o_res_rd_req),
        .o_res_rd_ptr(o_res_rd_ptr), .o_sw_reset(o_sw_reset), .o_crc_disable(o_crc_disable));

    always #5 i_ref_clk = ~i_ref_clk;

    // =====================================
    // Shared tasks
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge i_ref_clk);
            if (o_pready === 1'b1)
                break;
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (i == 20)
        begin
            n_mismatch++;
            end_sim();
        end
    endtask

    // Output watched by wait_for: 0 load request, 1 run, else resource read request
    function automatic logic pick(input int which);
        case (which)
            0: return o_tx_load_req;
            1: return o_tx_run;
            default: return o_res_rd_req;
        endcase
    endfunction

    task automatic wait_for(input int which, input logic v);
        int i;
        for (i = 0; i < 50 && pick(which) !== v; i++)
            @(posedge i_ref_clk);
        if (i == 50)
        begin
            n_mismatch++;
            end_sim();
        end
    endtask

    // Pulse select: 0 tally, 1 transmit loaded, else resource read done
    task automatic pulse(input int which);
        @(posedge i_ref_clk);
        case (which)
            0: i_rx_tally <= 1'b1;
            1: i_tx_loaded <= 1'b1;
            default: i_res_rd_done <= 1'b1;
        endcase
        @(posedge i_ref_clk);
        i_rx_tally <= 1'b0;
        i_tx_loaded <= 1'b0;
        i_res_rd_done <= 1'b0;
    endtask

    task automatic tally(input int n);
        repeat (n) pulse(0);
    endtask

    task automatic send_wb(input ncc_tx_wb_t v);
        @(posedge i_ref_clk);
        i_tx_wb <= v;
        i_tx_wb_valid <= 1'b1;
        @(posedge i_ref_clk);
        i_tx_wb_valid <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
    endtask

    // =====================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        apb(1'b0, `NCC_OFF_CMD, 32'h0);
        chk(rd, 32'h0080);
        chk(o_sw_reset & o_crc_disable, 1);
        apb(1'b1, `NCC_OFF_CMD, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        chk(err, 1);
        chk(rd, 32'h0);
        apb(1'b1, `NCC_OFF_CMD, 32'h0008);
        repeat (3) @(posedge i_ref_clk);
        chk(o_rx_buffer_en, 1);
        apb(1'b0, `NCC_OFF_CMD, 32'h0);
        chk(rd[3:2], 2'b10);
        i_rx_busy <= 1'b1;
        apb(1'b1, `NCC_OFF_CMD, 32'h0004);
        apb(1'b0, `NCC_OFF_CMD, 32'h0);
        chk({rd[3:2], o_rx_buffer_en}, 3'b111);
        i_rx_busy <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        chk(o_rx_buffer_en, 0);
        apb(1'b0, `NCC_OFF_CMD, 32'h0);
        chk(rd[3], 0);
        ntally = ($random(seed) & 7) + 1;
        tally(ntally);
        apb(1'b0, `NCC_OFF_TALLY, 32'h0);
        chk(rd, ntally);
        i_rx_busy <= 1'b1;
        apb(1'b1, `NCC_OFF_CMD, 32'h0008);
        apb(1'b0, `NCC_OFF_CMD, 32'h0);
        chk({rd[3:2], o_rx_buffer_en}, 3'b110);
        apb(1'b1, `NCC_OFF_CMD, 32'h0);
        apb(1'b0, `NCC_OFF_CMD, 32'h0);
        chk(rd[3:2], 2'b10);
        i_rx_busy <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        chk(o_rx_buffer_en, 1);
        // Six stop causes: end of list, halt, then each abort flag
        for (int k = 0; k < 6; k++)
        begin
            apb(1'b1, `NCC_OFF_CMD, 32'h0002);
            wait_for(0, 1'b1);
            chk(o_tx_run, 0);
            pulse(1);
            wait_for(1, 1'b1);
            wb = '0;
            wb.desc_addr = $random(seed);
            send_wb(wb);
            chk(o_tx_run, 1);
            if (k == 1)
            begin
                apb(1'b1, `NCC_OFF_CMD, 32'h0001);
                repeat (3) @(posedge i_ref_clk);
                chk(o_tx_run, 1);
            end
            wb.desc_addr = $random(seed);
            wb.end_of_list_flag = (k == 0);
            wb.excess_collision_flag = (k == 2);
            wb.excess_deferral_flag = (k == 3);
            wb.fifo_underrun_flag = (k == 4);
            wb.byte_count_mismatch_flag = (k == 5);
            send_wb(wb);
            chk(o_tx_run, 0);
            apb(1'b0, `NCC_OFF_CMD, 32'h0);
            chk(rd[1:0], 2'b00);
            apb(1'b0, `NCC_OFF_CUR_DESC, 32'h0);
            chk(rd, wb.desc_addr);
            apb(1'b0, `NCC_OFF_TX_STAT, 32'h0);
            chk(rd[3:0], {k == 2, k == 3, k == 4, k == 5});
        end
        ptr = $random(seed);
        apb(1'b1, `NCC_OFF_RES_PTR, ptr);
        apb(1'b1, `NCC_OFF_CMD, 32'h0100);
        wait_for(2, 1'b1);
        chk(o_res_rd_ptr, ptr);
        pulse(2);
        repeat (2) @(posedge i_ref_clk);
        chk(o_res_rd_req, 0);
        apb(1'b1, `NCC_OFF_CMD, 32'h0080);
        repeat (2) @(posedge i_ref_clk);
        chk({o_sw_reset, o_crc_disable, o_rx_buffer_en}, 3'b110);
        tally(3);
        apb(1'b0, `NCC_OFF_TALLY, 32'h0);
        chk(rd, ntally);
        apb(1'b1, `NCC_OFF_CMD, 32'h0);
        repeat (2) @(posedge i_ref_clk);
        chk(o_sw_reset, 0);
        end_sim();
    end
endmodule
